// [verilog/sse_spi_port.sv]
// top of the spi status and edge-select port with axi4-lite registers
// assumes pins are asynchronous and the bus master keeps axi4-lite rules
// Overview of operation
// RQ1 - master samples at end of output time if phase bit set, else middle
// RQ2 - software keeps the sample-phase bit clear when operating as slave
// RQ3 - idle low: edge bit set gives data stable on rising clock edge
// RQ4 - idle high: edge bit set gives data stable on falling clock edge
// RQ5 - buffer-full sets when a received byte lands, clear when empty
// RQ6 - status bits five to one carry nothing in spi mode, read zero
// RQ7 - reading the receive buffer clears buffer-full
// RQ8 - slave byte arriving while buffer full sets overflow, byte discarded
// RQ9 - clock polarity bit set means clock idles high, else low
// RQ10 - only phase and edge bits of status are software writable
module sse_spi_port
	import sse_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe_n,
	input wire logic i_sdi,
	output logic o_sdo,
	input wire logic i_ss_n,
	output logic o_irq
);
	sse_eng_if eng();
	logic [2:0] sync1_r, sync2_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, wlane_r;
	logic [1:0] bresp_r, rresp_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wbyte_r, rd_byte, rxbuf_r, tx_r;
	logic [31:0] rdata_r;
	logic smp_r, cke_r, bf_r, wcol_r, ovf_r, en_r, cpol_r, load_r, irq_r;
	logic [3:0] mode_r;
	logic [IRQ_W-1:0] irq_st_r, irq_mask_r, irq_ev, irq_clr;
	logic wr_fire, wr_en, rd_fire, buf_wr, buf_rd, irq_any;
	logic rx_accept, rx_ovf, wcol_ev;
	sse_sel_t wr_sel, rd_sel;

	sse_shift_engine u_engine (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.eng(eng.eng)
	);

	// ======================================================
	// pin synchronisers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sync1_r <= 3'h1;
			sync2_r <= 3'h1;
		end else begin
			sync1_r <= {i_sck, i_sdi, i_ss_n};
			sync2_r <= sync1_r;
		end
	end

	assign eng.sck_in = sync2_r[2];
	assign eng.sdi_in = sync2_r[1];
	assign eng.ss_n_in = sync2_r[0];
	// timer-sourced master clock falls back to the slowest divider
	assign eng.en = en_r && mode_r <= MODE_S_NOSS;
	assign eng.master = mode_r < MODE_S_SS;
	assign eng.ss_use = mode_r == MODE_S_SS;
	assign eng.half = (mode_r == MODE_M_DIV4) ? HALF_DIV4 :
		(mode_r == MODE_M_DIV16) ? HALF_DIV16 : HALF_DIV64;
	assign eng.cpol = cpol_r;
	assign eng.cke = cke_r;
	assign eng.input_sample_phase = smp_r;
	assign eng.load = load_r;
	assign eng.tx_data = tx_r;

	// ======================================================
	// axi4-lite write channel
	assign wr_fire = !awready_r && !wready_r && !bvalid_r;
	assign wr_en = wr_fire && wlane_r;
	assign wr_sel = sse_reg_sel(awaddr_r);
	assign rd_fire = i_arvalid && arready_r;
	assign rd_sel = sse_reg_sel(i_araddr);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= 8'h00;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else begin
			if (i_awvalid && awready_r) begin
				awaddr_r <= i_awaddr;
				awready_r <= 1'b0;
			end
			if (i_wvalid && wready_r) begin
				wbyte_r <= i_wdata[7:0];
				wlane_r <= i_wstrb[0];
				wready_r <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			if (bvalid_r && i_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// ======================================================
	// axi4-lite read channel
	always_comb begin
		unique case (rd_sel)
			// RQ6 unused status bits read zero
			SEL_STATUS: rd_byte = {smp_r, cke_r, 5'h00, bf_r};
			SEL_CONTROL: rd_byte = {wcol_r, ovf_r, en_r, cpol_r, mode_r};
			SEL_BUFFER: rd_byte = rxbuf_r;
			SEL_IRQ_ST: rd_byte = {5'h00, irq_st_r};
			SEL_IRQ_MASK: rd_byte = {5'h00, irq_mask_r};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			if (rd_fire) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rresp_r <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				rdata_r <= {24'h00_0000, rd_byte};
			end
			if (rvalid_r && i_rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// ======================================================
	// receive buffer and flags
	assign buf_wr = wr_en && wr_sel == SEL_BUFFER;
	assign buf_rd = rd_fire && rd_sel == SEL_BUFFER;
	// RQ8 discard when still full
	assign rx_ovf = eng.rx_done && !eng.master && bf_r;
	assign rx_accept = eng.rx_done && !rx_ovf;
	assign wcol_ev = buf_wr && eng.busy;

	// RQ10 status writes touch bits 7 and 6 only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			smp_r <= STATUS_RST[ST_SMP];
			cke_r <= STATUS_RST[ST_CKE];
		end else if (wr_en && wr_sel == SEL_STATUS) begin
			smp_r <= wbyte_r[ST_SMP];
			cke_r <= wbyte_r[ST_CKE];
		end
	end

	// RQ5 set on byte, set beats clear
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			bf_r <= STATUS_RST[ST_BF];
			rxbuf_r <= 8'h00;
		end else if (rx_accept) begin
			bf_r <= 1'b1;
			rxbuf_r <= eng.rx_data;
		end else if (buf_rd) begin
			// RQ7 read empties buffer
			bf_r <= 1'b0;
		end
	end

	// RQ9 polarity and mode from control
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			en_r <= CONTROL_RST[CT_EN];
			cpol_r <= CONTROL_RST[CT_CPOL];
			mode_r <= CONTROL_RST[3:0];
			wcol_r <= CONTROL_RST[CT_WCOL];
			ovf_r <= CONTROL_RST[CT_OVF];
		end else begin
			if (wr_en && wr_sel == SEL_CONTROL) begin
				en_r <= wbyte_r[CT_EN];
				cpol_r <= wbyte_r[CT_CPOL];
				mode_r <= wbyte_r[3:0];
			end
			// flags clear by writing zero, a new event wins
			if (wcol_ev) begin
				wcol_r <= 1'b1;
			end else if (wr_en && wr_sel == SEL_CONTROL && !wbyte_r[CT_WCOL]) begin
				wcol_r <= 1'b0;
			end
			if (rx_ovf) begin
				ovf_r <= 1'b1;
			end else if (wr_en && wr_sel == SEL_CONTROL && !wbyte_r[CT_OVF]) begin
				ovf_r <= 1'b0;
			end
		end
	end

	// writes while shifting are dropped and flagged
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			load_r <= 1'b0;
			tx_r <= 8'h00;
		end else begin
			load_r <= buf_wr && !eng.busy && eng.en;
			if (buf_wr && !eng.busy) begin
				tx_r <= wbyte_r;
			end
		end
	end

	// ======================================================
	// interrupts
	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_RX] = rx_accept;
		irq_ev[IRQ_OVF] = rx_ovf;
		irq_ev[IRQ_WCOL] = wcol_ev;
		irq_clr = (wr_en && wr_sel == SEL_IRQ_ST) ? wbyte_r[IRQ_W-1:0] : 3'h0;
		irq_any = |(irq_st_r & irq_mask_r);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_st_r <= 3'h0;
			irq_mask_r <= MASK_RST;
			irq_r <= 1'b0;
		end else begin
			irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
			irq_r <= irq_any;
			if (wr_en && wr_sel == SEL_IRQ_MASK) begin
				irq_mask_r <= wbyte_r[IRQ_W-1:0];
			end
		end
	end

	assign o_awready = awready_r;
	assign o_wready = wready_r;
	assign o_bresp = bresp_r;
	assign o_bvalid = bvalid_r;
	assign o_arready = arready_r;
	assign o_rdata = rdata_r;
	assign o_rresp = rresp_r;
	assign o_rvalid = rvalid_r;
	assign o_sck = eng.sck_out;
	assign o_sck_oe_n = eng.sck_oe_n;
	assign o_sdo = eng.sdo;
	assign o_irq = irq_r;

	// ======================================================
	// checks
	a_bf_set: // RQ5
	assert property (@(posedge i_clk) disable iff (i_reset)
		rx_accept |=> (bf_r && rxbuf_r == $past(eng.rx_data)))
		else $error("buffer full not set on byte");
	a_bf_clear: // RQ7
	assert property (@(posedge i_clk) disable iff (i_reset)
		(buf_rd && !rx_accept) |=> !bf_r)
		else $error("buffer read did not clear full flag");
	a_ovf_drop: // RQ8
	assert property (@(posedge i_clk) disable iff (i_reset)
		(rx_ovf && !buf_rd) |=> (ovf_r && bf_r && $stable(rxbuf_r)))
		else $error("overflow byte not discarded");
	a_status_zero: // RQ6
	assert property (@(posedge i_clk) disable iff (i_reset)
		(rd_fire && rd_sel == SEL_STATUS) |=> (rdata_r[5:1] == 5'h00))
		else $error("unused status bits not zero");
	a_status_ro: // RQ10
	assert property (@(posedge i_clk) disable iff (i_reset)
		(wr_en && wr_sel == SEL_STATUS && !bf_r && !rx_accept) |=> !bf_r)
		else $error("software set buffer full");
	a_irq_level:
	assert property (@(posedge i_clk) disable iff (i_reset)
		1'b1 |=> (irq_r == $past(irq_any)))
		else $error("interrupt output wrong");
endmodule : sse_spi_port

// [verilog/sse_pkg.sv]
// constants, register map and types of the spi status and edge-select port
// assumes a 10 MHz system clock and a 32-bit axi4-lite register bus
package sse_pkg;
	// ======================================================
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_BUFFER = 8'h08;
	localparam logic [7:0] OFF_IRQ_ST = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	typedef enum logic [2:0] {
		SEL_STATUS, SEL_CONTROL, SEL_BUFFER, SEL_IRQ_ST, SEL_IRQ_MASK, SEL_NONE
	} sse_sel_t;
	// ======================================================
	// field positions and reset values
	localparam int ST_SMP = 7;
	localparam int ST_CKE = 6;
	localparam int ST_BF = 0;
	localparam int CT_WCOL = 7;
	localparam int CT_OVF = 6;
	localparam int CT_EN = 5;
	localparam int CT_CPOL = 4;
	localparam int IRQ_RX = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_WCOL = 2;
	localparam int IRQ_W = 3;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
	// ======================================================
	// modes and timing
	localparam logic [3:0] MODE_M_DIV4 = 4'h0;
	localparam logic [3:0] MODE_M_DIV16 = 4'h1;
	localparam logic [3:0] MODE_M_DIV64 = 4'h2;
	localparam logic [3:0] MODE_M_TMR = 4'h3;
	localparam logic [3:0] MODE_S_SS = 4'h4;
	localparam logic [3:0] MODE_S_NOSS = 4'h5;
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [4:0] TICK_LAST = 5'h10;
	localparam logic [3:0] BITS_LAST = 4'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {M_IDLE = 2'b01, M_RUN = 2'b10} sse_mstate_t;

	function automatic sse_sel_t sse_reg_sel(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFF_STATUS: sse_reg_sel = SEL_STATUS;
			OFF_CONTROL: sse_reg_sel = SEL_CONTROL;
			OFF_BUFFER: sse_reg_sel = SEL_BUFFER;
			OFF_IRQ_ST: sse_reg_sel = SEL_IRQ_ST;
			OFF_IRQ_MASK: sse_reg_sel = SEL_IRQ_MASK;
			default: sse_reg_sel = SEL_NONE;
		endcase
	endfunction : sse_reg_sel
endpackage : sse_pkg

// [verilog/sse_eng_if.sv]
// interface between the register side and the shift engine
// assumes both ends run on the same system clock
interface sse_eng_if;
	logic en, master, cpol, cke, input_sample_phase, ss_use, load;
	logic [5:0] half;
	logic [7:0] tx_data;
	logic rx_done, busy;
	logic [7:0] rx_data;
	logic sck_in, sdi_in, ss_n_in;
	logic sck_out, sck_oe_n, sdo;
	modport ctl (output en, master, cpol, cke, input_sample_phase, ss_use, load, half,
		tx_data, sck_in, sdi_in, ss_n_in,
		input rx_done, busy, rx_data, sck_out, sck_oe_n, sdo);
	modport eng (input en, master, cpol, cke, input_sample_phase, ss_use, load, half,
		tx_data, sck_in, sdi_in, ss_n_in,
		output rx_done, busy, rx_data, sck_out, sck_oe_n, sdo);
endinterface : sse_eng_if

// [verilog/sse_shift_engine.sv]
// spi shift engine: master clock generation, slave edge detection
// assumes pin inputs arrive already synchronised to i_clk
module sse_shift_engine
	import sse_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	sse_eng_if.eng eng
);
	sse_mstate_t st_r;
	logic [5:0] div_r;
	logic [4:0] k_r;
	logic [3:0] bits_r;
	logic [7:0] sh_r, rx_sh_r, rx_data_r, rx_next;
	logic sck_prev_r, sck_r, oe_n_r, sdo_r, rx_done_r;
	logic tick, m_tick, m_shift, m_mid, s_sel, s_lead, s_trail;
	logic do_samp, do_shift, done;

	// ======================================================
	// edge selection
	always_comb begin
		tick = (div_r == eng.half - 6'h01);
		m_tick = eng.master && st_r == M_RUN && tick;
		// RQ3 shift edge choice
		m_shift = eng.cke ? k_r[0] : (!k_r[0] && k_r != 5'h00);
		m_mid = eng.cke ? (!k_r[0] && k_r != TICK_LAST) : k_r[0];
		s_sel = eng.en && !eng.master && !(eng.ss_use && eng.ss_n_in);
		s_lead = eng.sck_in != sck_prev_r && eng.sck_in != eng.cpol;
		s_trail = eng.sck_in != sck_prev_r && eng.sck_in == eng.cpol;
		if (eng.master) begin
			// RQ1 sample at end or middle
			do_samp = m_tick && (eng.input_sample_phase ? m_shift : m_mid);
			do_shift = m_tick && m_shift;
			done = m_tick && k_r == TICK_LAST;
		end else begin
			// RQ2 phase bit ignored as slave
			do_samp = s_sel && (eng.cke ? s_lead : s_trail);
			// RQ4 slave shift edge
			do_shift = s_sel && (eng.cke ? s_trail : s_lead) && bits_r != 4'h0;
			done = do_samp && bits_r == BITS_LAST;
		end
		rx_next = do_samp ? {rx_sh_r[6:0], eng.sdi_in} : rx_sh_r;
	end

	assign eng.busy = eng.master ? (st_r == M_RUN) : (bits_r != 4'h0);
	assign eng.rx_done = rx_done_r;
	assign eng.rx_data = rx_data_r;
	assign eng.sck_out = sck_r;
	assign eng.sck_oe_n = oe_n_r;
	assign eng.sdo = sdo_r;

	// ======================================================
	// master sequencer: 16 clock half periods plus one closing tick
	always_ff @(posedge i_clk) begin
		if (i_reset || !eng.en || !eng.master) begin
			st_r <= M_IDLE;
			div_r <= 6'h00;
			k_r <= 5'h00;
		end else begin
			unique case (st_r)
				M_IDLE: begin
					div_r <= 6'h00;
					k_r <= 5'h00;
					if (eng.load) begin
						st_r <= M_RUN;
					end
				end
				M_RUN: begin
					if (tick) begin
						div_r <= 6'h00;
						k_r <= k_r + 5'h01;
						if (k_r == TICK_LAST) begin
							st_r <= M_IDLE;
						end
					end else begin
						div_r <= div_r + 6'h01;
					end
				end
			endcase
		end
	end

	// RQ9 clock idles at polarity level
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sck_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= !(eng.en && eng.master);
			if (st_r != M_RUN) begin
				sck_r <= eng.cpol;
			end else if (m_tick && k_r != TICK_LAST) begin
				sck_r <= ~sck_r;
			end
		end
	end

	// ======================================================
	// shift data
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sck_prev_r <= 1'b0;
			sh_r <= 8'h00;
			sdo_r <= 1'b0;
			rx_sh_r <= 8'h00;
			rx_data_r <= 8'h00;
			rx_done_r <= 1'b0;
			bits_r <= 4'h0;
		end else begin
			sck_prev_r <= eng.sck_in;
			rx_done_r <= done;
			rx_sh_r <= rx_next;
			if (done) begin
				rx_data_r <= rx_next;
			end
			if (eng.master || !s_sel) begin
				bits_r <= 4'h0;
			end else if (do_samp) begin
				bits_r <= done ? 4'h0 : bits_r + 4'h1;
			end
			if (eng.load && !eng.busy) begin
				sh_r <= eng.tx_data;
				sdo_r <= eng.tx_data[7];
			end else if (do_shift) begin
				sh_r <= {sh_r[6:0], 1'b0};
				sdo_r <= sh_r[6];
			end
		end
	end

	// ======================================================
	// checks
	a_sample_end: // RQ1
	assert property (@(posedge i_clk) disable iff (i_reset)
		(m_tick && eng.input_sample_phase) |-> (do_samp == m_shift))
		else $error("master end sample misplaced");
	a_sample_mid: // RQ1
	assert property (@(posedge i_clk) disable iff (i_reset)
		(m_tick && !eng.input_sample_phase) |-> (do_samp == m_mid))
		else $error("master middle sample misplaced");
	a_edge_pol_low: // RQ3
	assert property (@(posedge i_clk) disable iff (i_reset)
		(do_shift && eng.master && !eng.cpol && k_r != TICK_LAST)
		|=> (sck_r == !eng.cke))
		else $error("data changed on wrong edge, idle low");
	a_edge_pol_high: // RQ4
	assert property (@(posedge i_clk) disable iff (i_reset)
		(do_shift && eng.master && eng.cpol && k_r != TICK_LAST)
		|=> (sck_r == eng.cke))
		else $error("data changed on wrong edge, idle high");
	a_idle_level: // RQ9
	assert property (@(posedge i_clk) disable iff (i_reset)
		(st_r == M_IDLE && $past(st_r) == M_IDLE && $stable(eng.cpol))
		|-> (sck_r == eng.cpol))
		else $error("clock not at idle level");
endmodule : sse_shift_engine

// [sim/sse_spi_peer.sv]
// behavioural spi peer: slave to the port as master, master to it as slave
// assumes the bench sets polarity and edge before it pulses arm
module sse_spi_peer (
	input wire logic i_cpol,
	input wire logic i_cke,
	input wire logic i_mine,
	input wire logic i_arm,
	input wire logic [7:0] i_tx,
	input wire logic i_sck,
	input wire logic i_sdo,
	output logic o_sck,
	output logic o_sdi,
	output logic o_ss_n,
	output logic [7:0] o_rx,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	wire logic line;
	assign line = i_mine ? o_sck : i_sck;
	initial begin
		o_sck = 1'b0;
		o_sdi = 1'b0;
		o_ss_n = 1'b1;
		o_rx = 8'h00;
		o_busy = 1'b0;
		cnt = 4'h0;
	end
	// ======================================================
	// frame start
	// clock stands still at idle level between frames, phase unrelated
	always @(posedge i_arm) begin
		cnt = 4'h0;
		o_sdi = i_tx[7];
		o_sck = i_cpol;
		o_busy = 1'b1;
		if (i_mine) begin
			#37 o_ss_n = 1'b0;
			repeat (16) begin
				#400 o_sck = ~o_sck;
			end
			#400 o_ss_n = 1'b1;
			// deselected line shows no stale bit
			o_sdi = ~o_sdi;
		end
		o_busy = 1'b0;
	end
	// ======================================================
	// sample and shift
	// stable edge is rising when polarity and edge bit differ
	always @(line) begin
		if (line === (i_cpol ^ i_cke)) begin
			o_rx = {o_rx[6:0], i_sdo};
			cnt = cnt + 4'h1;
		end else if (cnt >= 4'h8) begin
			// past the byte: keep the line moving, never a stale bit
			o_sdi = ~o_sdi;
		end else if (cnt != 4'h0) begin
			o_sdi = i_tx[3'd7 - cnt[2:0]];
		end
	end
endmodule : sse_spi_peer

// [sim/sse_spi_port_bench.sv]
// self-checking bench of the spi port: axi4-lite master tasks and a peer
// assumes 100 ns system clock and an 800 ns peer serial clock
module sse_spi_port_bench
	import sse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic cpol = 1'b0;
	logic cke = 1'b0;
	logic mine = 1'b0;
	logic arm = 1'b0;
	logic [7:0] ptx = 8'h00;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic sck, sck_oe_n, sdo, irq, psck, psdi, pss_n, pbusy;
	wire logic [7:0] prx;
	logic [31:0] rv;
	logic [1:0] resp;
	int errors = 0;
	int n_checks = 0;
	always #50 clk = ~clk;
	sse_spi_port i_sse_spi_port (.i_clk(clk), .i_reset(rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .i_sck(psck), .o_sck(sck),
		.o_sck_oe_n(sck_oe_n), .i_sdi(psdi), .o_sdo(sdo), .i_ss_n(pss_n),
		.o_irq(irq));
	sse_spi_peer i_sse_spi_peer (.i_cpol(cpol), .i_cke(cke), .i_mine(mine),
		.i_arm(arm), .i_tx(ptx), .i_sck(sck), .i_sdo(sdo), .o_sck(psck),
		.o_sdi(psdi), .o_ss_n(pss_n), .o_rx(prx), .o_busy(pbusy));
	// ======================================================
	// report and checks
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	task stuck;
		$display("ERROR wait expected done seen stuck");
		errors++;
		report_and_stop;
	endtask : stuck
	// ======================================================
	// axi4-lite master: one edge of gap so no strobe is set twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) stuck;
		resp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) stuck;
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic wait_peer;
		int n;
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		for (n = 0; n < 400; n++) begin
			@(posedge clk);
			if (!pbusy) break;
		end
		if (n == 400) stuck;
		repeat (5) @(posedge clk);
	endtask : wait_peer
	// ======================================================
	// scenarios
	task t_reset;
		rd(OFF_STATUS);
		chk("status", 8'h00, rv[7:0]);
		rd(OFF_CONTROL);
		chk("control", 8'h00, rv[7:0]);
		chk("sck_oe_n", 8'h01, {7'h0, sck_oe_n});
		chk("irq", 8'h00, {7'h0, irq});
	endtask : t_reset
	task t_regs;
		wr(OFF_STATUS, 8'hff);
		rd(OFF_STATUS);
		chk("status", 8'hc0, rv[7:0]);
		wr(OFF_STATUS, 8'h00);
		rd(8'h14);
		chk("rresp", 8'h02, {6'h0, resp});
		wr(8'h14, 8'h01);
		chk("bresp", 8'h02, {6'h0, resp});
	endtask : t_regs
	task automatic t_master(input logic [1:0] i);
		int n;
		logic [7:0] d;
		logic [7:0] b;
		d = 8'ha5 ^ {6'h0, i};
		b = 8'h3c ^ {i, 6'h0};
		cpol <= i[1];
		cke <= i[0];
		mine <= 1'b0;
		ptx <= b;
		wr(OFF_CONTROL, {3'b001, i[1], 4'h1});
		wr(OFF_STATUS, {i[1], i[0], 6'h0});
		chk("sck_idle", {7'h0, i[1]}, {7'h0, sck});
		chk("sck_oe_n", 8'h00, {7'h0, sck_oe_n});
		arm <= 1'b1;
		wr(OFF_BUFFER, d);
		arm <= 1'b0;
		if (i == 2'd0) begin
			// second byte while shifting is dropped and flagged
			wr(OFF_BUFFER, 8'h00);
			rd(OFF_CONTROL);
			chk("write_collision", 8'ha1, rv[7:0]);
		end
		for (n = 0; n < 100; n++) begin
			rd(OFF_STATUS);
			if (rv[0]) break;
		end
		if (n == 100) stuck;
		chk("status", {i[1], i[0], 6'h01}, rv[7:0]);
		if (i == 2'd0) begin
			chk("irq_masked", 8'h00, {7'h0, irq});
			wr(OFF_IRQ_MASK, 8'h01);
			repeat (2) @(posedge clk);
			chk("irq", 8'h01, {7'h0, irq});
			wr(OFF_IRQ_ST, 8'h05);
			rd(OFF_IRQ_ST);
			chk("irq_status", 8'h00, rv[7:0]);
			chk("irq", 8'h00, {7'h0, irq});
			wr(OFF_IRQ_MASK, 8'h00);
		end
		rd(OFF_BUFFER);
		chk("rx_byte", b, rv[7:0]);
		chk("peer_rx", d, prx);
		rd(OFF_STATUS);
		chk("buffer_full", 8'h00, {7'h0, rv[0]});
	endtask : t_master
	task t_slave;
		cpol <= 1'b0;
		cke <= 1'b1;
		mine <= 1'b1;
		ptx <= 8'h3c;
		wr(OFF_STATUS, 8'h40);
		wr(OFF_CONTROL, 8'h25);
		wr(OFF_BUFFER, 8'h96);
		wait_peer;
		rd(OFF_STATUS);
		chk("status", 8'h41, rv[7:0]);
		chk("peer_rx", 8'h96, prx);
		// second byte lands on a full buffer and must be dropped
		ptx <= 8'hc3;
		wait_peer;
		rd(OFF_CONTROL);
		chk("control", 8'h65, rv[7:0]);
		rd(OFF_IRQ_ST);
		chk("irq_overflow", 8'h01, {7'h0, rv[1]});
		rd(OFF_BUFFER);
		chk("rx_byte", 8'h3c, rv[7:0]);
		// select-gated slave; writing zero clears the overflow flag
		wr(OFF_CONTROL, 8'h24);
		wr(OFF_BUFFER, 8'h69);
		ptx <= 8'h5a;
		wait_peer;
		rd(OFF_CONTROL);
		chk("control", 8'h24, rv[7:0]);
		rd(OFF_BUFFER);
		chk("rx_byte", 8'h5a, rv[7:0]);
		chk("peer_rx", 8'h69, prx);
	endtask : t_slave
	// ======================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_regs;
		for (int k = 0; k < 4; k++) begin
			t_master(2'(k));
		end
		t_slave;
		report_and_stop;
	end
endmodule : sse_spi_port_bench
